// [core/memctl_perf_event_filter.sv]
// Performance event filter with its APB register file and counter
//
// The APB slave port and the address map were left to the implementer.
`timescale 1ns/1ps
module memctl_perf_event_filter (
   input  wire logic        clk,
   input  wire logic        rst,
   input  wire logic        psel,
   input  wire logic        penable,
   input  wire logic        pwrite,
   input  wire logic [11:0] paddr,
   input  wire logic [31:0] pwdata,
   output logic      [31:0] prdata,
   output logic             pready,
   output logic             pslverr,
   input  wire logic        thermal_rise_crossing_event,
   input  wire logic [1:0]  crossing_trip,
   input  wire logic [2:0]  crossing_dimm,
   input  wire logic        translated_command_event,
   input  wire logic        command_read_class,
   input  wire logic        throttle_conflict_event,
   input  wire logic [3:0]  conflict_rank,
   output logic      [31:0] event_count
);
   // ------------------------------------------------------------
   // Registers
   // ------------------------------------------------------------
   logic [7:0]  event_code_r;
   logic [10:0] thermal_filter_r;
   logic [9:0]  page_filter_r;
   logic [31:0] count_r;
   logic [31:0] count_nxt;
   logic        pready_r;
   logic [31:0] prdata_r;
   logic        pslverr_r;
   event_qual_if qi ();
   // ------------------------------------------------------------
   // Qualifier
   // ------------------------------------------------------------
   assign qi.event_code                  = event_code_r;
   assign qi.thermal_filter_field        = thermal_filter_r;
   assign qi.page_filter_field           = page_filter_r;
   assign qi.thermal_rise_crossing_event = thermal_rise_crossing_event;
   assign qi.crossing_trip               = crossing_trip;
   assign qi.crossing_dimm               = crossing_dimm;
   assign qi.translated_command_event    = translated_command_event;
   assign qi.command_read_class          = command_read_class;
   assign qi.throttle_conflict_event     = throttle_conflict_event;
   assign qi.conflict_rank               = conflict_rank;
   event_qualifier u_qual (
      .q (qi.qual)
   );
   // ------------------------------------------------------------
   // APB decode
   // ------------------------------------------------------------
   wire access   = psel && penable && !pready_r;
   wire commit   = psel && penable && pready_r;
   wire sel_ev   = (paddr == perf_filter_pkg::EVSEL_OFF);
   wire sel_thr  = (paddr == perf_filter_pkg::THRFLT_OFF);
   wire sel_pg   = (paddr == perf_filter_pkg::PGFLT_OFF);
   wire sel_cnt  = (paddr == perf_filter_pkg::COUNT_OFF);
   wire mapped   = sel_ev || sel_thr || sel_pg || sel_cnt;
   wire wr_en    = commit && pwrite && mapped;
   wire cnt_wr   = wr_en && sel_cnt;
   wire [31:0] rd_mux = sel_ev  ? {24'h000000, event_code_r} :
                        sel_thr ? {21'h00000, thermal_filter_r} :
                        sel_pg  ? {22'h00000, page_filter_r} :
                        sel_cnt ? count_r : 32'h0000_0000;
   // Counter: software load wins, otherwise one per qualified event
   assign count_nxt = cnt_wr ? pwdata :
                      qi.hit ? count_r + 32'h0000_0001 : count_r;
   // ------------------------------------------------------------
   // Sequential
   // ------------------------------------------------------------
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         pready_r  <= 1'b0;
         prdata_r  <= 32'h0000_0000;
         pslverr_r <= 1'b0;
      end else begin
         pready_r  <= access;
         pslverr_r <= access && !mapped;
         prdata_r  <= (access && !pwrite) ? rd_mux : 32'h0000_0000;
      end
   end
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         event_code_r     <= perf_filter_pkg::EVSEL_RST;
         thermal_filter_r <= perf_filter_pkg::THRFLT_RST;
         page_filter_r    <= perf_filter_pkg::PGFLT_RST;
      end else if (wr_en) begin
         if (sel_ev) begin
            event_code_r <= pwdata[7:0];
         end
         if (sel_thr) begin
            thermal_filter_r <= pwdata[10:0];
         end
         if (sel_pg) begin
            page_filter_r <= pwdata[9:0];
         end
      end
   end
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         count_r <= perf_filter_pkg::COUNT_RST;
      end else begin
         count_r <= count_nxt;
      end
   end
   assign prdata      = prdata_r;
   assign pready      = pready_r;
   assign pslverr     = pslverr_r;
   assign event_count = count_r;
   // ------------------------------------------------------------
   // Assertions
   // ------------------------------------------------------------
   default clocking cb @(posedge clk); endclocking
   default disable iff (rst);
   wire ev_th  = (event_code_r == perf_filter_pkg::EV_THERMAL_RISE);
   wire ev_tc  = (event_code_r == perf_filter_pkg::EV_TRANSLATED);
   wire ev_tt  = (event_code_r == perf_filter_pkg::EV_THROTTLE);
   wire quiet  = !thermal_rise_crossing_event && !translated_command_event &&
                 !throttle_conflict_event;
   property p_therm_count;
      ev_th && thermal_rise_crossing_event && !cnt_wr &&
      (crossing_trip == thermal_filter_r[10:9]) && thermal_filter_r[3]
      |=> event_count == $past(event_count) + 32'h0000_0001;
   endproperty
   a_therm_count: assert property (p_therm_count)
      else $error("thermal crossing not counted");
   property p_therm_idle;
      ev_th && !thermal_rise_crossing_event && !cnt_wr |=> $stable(event_count);
   endproperty
   a_therm_idle: assert property (p_therm_idle)
      else $error("counter moved without crossing");
   property p_trip_reject;
      ev_th && !cnt_wr && (crossing_trip != thermal_filter_r[10:9]) |=> $stable(event_count);
   endproperty
   a_trip_reject: assert property (p_trip_reject)
      else $error("wrong trip point counted");
   property p_dimm_reject;
      ev_th && !cnt_wr && !thermal_filter_r[3] && (crossing_dimm != thermal_filter_r[6:4])
      |=> $stable(event_count);
   endproperty
   a_dimm_reject: assert property (p_dimm_reject)
      else $error("other dimm counted");
   property p_dimm_match;
      ev_th && thermal_rise_crossing_event && !cnt_wr && !thermal_filter_r[3] &&
      (crossing_dimm == thermal_filter_r[6:4]) && (crossing_trip == thermal_filter_r[10:9])
      |=> event_count == $past(event_count) + 32'h0000_0001;
   endproperty
   a_dimm_match: assert property (p_dimm_match)
      else $error("named dimm not counted");
   property p_cmd_all;
      ev_tc && translated_command_event && !cnt_wr && (page_filter_r[9:8] == 2'h0)
      |=> event_count == $past(event_count) + 32'h0000_0001;
   endproperty
   a_cmd_all: assert property (p_cmd_all)
      else $error("insert not counted");
   property p_cmd_read;
      ev_tc && !cnt_wr && (page_filter_r[9:8] == 2'h1) && !command_read_class
      |=> $stable(event_count);
   endproperty
   a_cmd_read: assert property (p_cmd_read)
      else $error("write counted as read");
   property p_cmd_read_hit;
      ev_tc && translated_command_event && command_read_class && !cnt_wr &&
      (page_filter_r[9:8] == 2'h1)
      |=> event_count == $past(event_count) + 32'h0000_0001;
   endproperty
   a_cmd_read_hit: assert property (p_cmd_read_hit)
      else $error("read insert not counted");
   property p_cmd_write;
      ev_tc && !cnt_wr && (page_filter_r[9:8] == 2'h2) && command_read_class
      |=> $stable(event_count);
   endproperty
   a_cmd_write: assert property (p_cmd_write)
      else $error("read counted as write");
   property p_cmd_none;
      ev_tc && !cnt_wr && (page_filter_r[9:8] == 2'h3) |=> $stable(event_count);
   endproperty
   a_cmd_none: assert property (p_cmd_none)
      else $error("mode three counted");
   property p_tt_any;
      ev_tt && throttle_conflict_event && !cnt_wr && !page_filter_r[1]
      |=> event_count == $past(event_count) + 32'h0000_0001;
   endproperty
   a_tt_any: assert property (p_tt_any)
      else $error("conflict not counted");
   property p_tt_rank;
      ev_tt && !cnt_wr && page_filter_r[1] && (conflict_rank != page_filter_r[5:2])
      |=> $stable(event_count);
   endproperty
   a_tt_rank: assert property (p_tt_rank)
      else $error("other rank counted");
   property p_tt_rank_hit;
      ev_tt && throttle_conflict_event && !cnt_wr && page_filter_r[1] &&
      (conflict_rank == page_filter_r[5:2])
      |=> event_count == $past(event_count) + 32'h0000_0001;
   endproperty
   a_tt_rank_hit: assert property (p_tt_rank_hit)
      else $error("named rank not counted");
   property p_hold;
      quiet && !cnt_wr |=> $stable(event_count);
   endproperty
   a_hold: assert property (p_hold)
      else $error("counter moved without event");
   property p_other_code;
      !ev_th && !ev_tc && !ev_tt && !cnt_wr |=> $stable(event_count);
   endproperty
   a_other_code: assert property (p_other_code)
      else $error("unknown event code counted");
   property p_count_load;
      cnt_wr |=> event_count == $past(pwdata);
   endproperty
   a_count_load: assert property (p_count_load)
      else $error("counter load lost");
   property p_apb_answer;
      psel && penable && !pready |=> pready ##1 !pready;
   endproperty
   a_apb_answer: assert property (p_apb_answer)
      else $error("apb answer timing wrong");
   property p_err_pulse;
      pslverr |-> pready;
   endproperty
   a_err_pulse: assert property (p_err_pulse)
      else $error("error without ready");
   property p_rd_idle;
      !pready |-> (prdata == 32'h0000_0000);
   endproperty
   a_rd_idle: assert property (p_rd_idle)
      else $error("read data outside answer");
   c_therm: cover property (ev_th && qi.hit ##1 ev_th && qi.hit);
   c_cmd_read: cover property (ev_tc && qi.hit && page_filter_r[9:8] == 2'h1);
   c_tt_rank: cover property (ev_tt && qi.hit && page_filter_r[1]);
   c_count_load: cover property (cnt_wr);
   c_apb_err: cover property (pslverr);
endmodule

// [core/perf_filter_pkg.sv]
// Constants for the memory-controller performance event filter
// How it works
// - Event code 0x04 adds one per cycle when a selected DIMM trip point is crossed upward.
// - Thermal bits 10:9 pick the trip: 3 mid rising, 2 mid falling, 1 low, 0 below low.
// - Thermal filter bit 3 set counts any DIMM, clear counts only the named DIMM.
// - Event code 0x12 adds one per cycle as commands enter any dispatch queue.
// - Page filter bits 9:8 equal to 1 count only read-class command inserts.
// - Page filter bits 9:8 at 0 count every insert, 2 write inserts, 3 nothing.
// - Event code 0x19 adds one per cycle on each throttling command conflict.
// - Page filter bit 1 clear counts any rank, set counts only the rank in bits 5:2.
package perf_filter_pkg;
   // ------------------------------------------------------------
   // Register map
   // ------------------------------------------------------------
   localparam logic [11:0] EVSEL_OFF  = 12'h000;
   localparam logic [11:0] THRFLT_OFF = 12'h004;
   localparam logic [11:0] PGFLT_OFF  = 12'h008;
   localparam logic [11:0] COUNT_OFF  = 12'h00C;
   // ------------------------------------------------------------
   // Event codes
   // ------------------------------------------------------------
   localparam logic [7:0] EV_THERMAL_RISE = 8'h04;
   localparam logic [7:0] EV_TRANSLATED   = 8'h12;
   localparam logic [7:0] EV_THROTTLE     = 8'h19;
   // ------------------------------------------------------------
   // Field layout
   // ------------------------------------------------------------
   localparam int EVSEL_W    = 8;
   localparam int THRFLT_W   = 11;
   localparam int PGFLT_W    = 10;
   localparam int TRIP_LSB   = 9;
   localparam int ANYDIMM_B  = 3;
   localparam int DIMM_LSB   = 4;
   localparam int INSMODE_LSB = 8;
   localparam int ONERANK_B  = 1;
   localparam int RANK_LSB   = 2;
   localparam int DIMM_W     = 3;
   localparam int RANK_W     = 4;
   localparam logic [1:0] every_queue_insert = 2'h0;
   localparam logic [1:0] read_queue_inserts = 2'h1;
   localparam logic [1:0] write_queue_inserts = 2'h2;
   localparam logic [1:0] above_middle_rising_trip  = 2'h3;
   localparam logic [1:0] above_middle_falling_trip = 2'h2;
   localparam logic [1:0] between_low_middle_trip   = 2'h1;
   localparam logic [1:0] below_low_trip            = 2'h0;
   // ------------------------------------------------------------
   // Reset values
   // ------------------------------------------------------------
   localparam logic [7:0]  EVSEL_RST  = 8'h00;
   localparam logic [10:0] THRFLT_RST = 11'h000;
   localparam logic [9:0]  PGFLT_RST  = 10'h000;
   localparam logic [31:0] COUNT_RST  = 32'h0000_0000;
endpackage

// [core/event_qual_if.sv]
// Carrier between the filter registers and the event qualifier
`timescale 1ns/1ps
interface event_qual_if;
   logic [7:0]  event_code;
   logic [10:0] thermal_filter_field;
   logic [9:0]  page_filter_field;
   logic        thermal_rise_crossing_event;
   logic [1:0]  crossing_trip;
   logic [2:0]  crossing_dimm;
   logic        translated_command_event;
   logic        command_read_class;
   logic        throttle_conflict_event;
   logic [3:0]  conflict_rank;
   logic        hit;
   modport qual (input event_code, thermal_filter_field, page_filter_field,
                 thermal_rise_crossing_event, crossing_trip, crossing_dimm,
                 translated_command_event, command_read_class,
                 throttle_conflict_event, conflict_rank, output hit);
   modport ctrl (output event_code, thermal_filter_field, page_filter_field,
                 thermal_rise_crossing_event, crossing_trip, crossing_dimm,
                 translated_command_event, command_read_class,
                 throttle_conflict_event, conflict_rank, input hit);
endinterface

// [core/event_qualifier.sv]
// Qualifies the three filtered events against the programmed fields
`timescale 1ns/1ps
module event_qualifier (
   event_qual_if.qual q
);
   // ------------------------------------------------------------
   // Thermal crossing
   // ------------------------------------------------------------
   wire [1:0] trip_sel = q.thermal_filter_field[perf_filter_pkg::TRIP_LSB +: 2];
   wire       any_dimm = q.thermal_filter_field[perf_filter_pkg::ANYDIMM_B];
   wire [2:0] dimm_sel =
      q.thermal_filter_field[perf_filter_pkg::DIMM_LSB +: perf_filter_pkg::DIMM_W];
   wire       trip_ok  = (q.crossing_trip == trip_sel);
   wire       dimm_ok  = any_dimm || (q.crossing_dimm == dimm_sel);
   wire       therm_hit = q.thermal_rise_crossing_event && trip_ok && dimm_ok;
   // ------------------------------------------------------------
   // Dispatch queue inserts
   // ------------------------------------------------------------
   wire [1:0] ins_mode = q.page_filter_field[perf_filter_pkg::INSMODE_LSB +: 2];
   wire       class_ok = (ins_mode == perf_filter_pkg::every_queue_insert) ||
                         ((ins_mode == perf_filter_pkg::read_queue_inserts) &&
                          q.command_read_class) ||
                         ((ins_mode == perf_filter_pkg::write_queue_inserts) &&
                          !q.command_read_class);
   wire       cmd_hit  = q.translated_command_event && class_ok;
   // ------------------------------------------------------------
   // Throttle conflicts
   // ------------------------------------------------------------
   wire       one_rank = q.page_filter_field[perf_filter_pkg::ONERANK_B];
   wire [3:0] rank_sel = q.page_filter_field[perf_filter_pkg::RANK_LSB +: perf_filter_pkg::RANK_W];
   wire       tt_hit   = q.throttle_conflict_event &&
                         (!one_rank || (q.conflict_rank == rank_sel));
   // ------------------------------------------------------------
   // Event select
   // ------------------------------------------------------------
   wire       code_th  = (q.event_code == perf_filter_pkg::EV_THERMAL_RISE);
   wire       code_tc  = (q.event_code == perf_filter_pkg::EV_TRANSLATED);
   wire       code_tt  = (q.event_code == perf_filter_pkg::EV_THROTTLE);
   assign q.hit = (code_th && therm_hit) || (code_tc && cmd_hit) || (code_tt && tt_hit);
endmodule

// [testbench/tb_memctl_perf_event_filter.sv]
// Self-checking bench for the performance event filter
`timescale 1ns/1ps
`define CHK(g, e) begin n_checks++; if ((g) !== (e)) begin fail_count++; \
   $display("[ERR] %0t: mismatch got %0h exp %0h", $time, (g), (e)); end end
module tb_memctl_perf_event_filter;
   // ------------------------------------------------------------
   // Signals
   // ------------------------------------------------------------
   logic        clk = 1'b0;
   logic        rst = 1'b1;
   logic        psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
   logic [11:0] paddr = 12'h000;
   logic [31:0] pwdata = 32'h0000_0000;
   logic [31:0] prdata, event_count, exp_cnt, rd;
   logic        pready, pslverr, er;
   logic        th = 1'b0, tc = 1'b0, rc = 1'b0, tt = 1'b0;
   logic [1:0]  trip = 2'h0;
   logic [2:0]  dimm = 3'h0;
   logic [3:0]  rank = 4'h0;
   int          fail_count = 0, n_checks = 0, cycles = 0;
   always #5 clk = ~clk;
   memctl_perf_event_filter dut_u (.clk(clk), .rst(rst), .psel(psel), .penable(penable),
      .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
      .pslverr(pslverr), .thermal_rise_crossing_event(th), .crossing_trip(trip),
      .crossing_dimm(dimm), .translated_command_event(tc), .command_read_class(rc),
      .throttle_conflict_event(tt), .conflict_rank(rank), .event_count(event_count));
   // ------------------------------------------------------------
   // Tasks
   // ------------------------------------------------------------
   task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
      @(posedge clk);
      psel <= 1'b1;
      penable <= 1'b0;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge clk);
      penable <= 1'b1;
      do @(posedge clk); while (pready !== 1'b1);
      rd = prdata;
      er = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask
   task automatic ev(input logic t_th, input logic [1:0] t_trip, input logic [2:0] t_dimm,
                     input logic t_tc, input logic t_rc, input logic t_tt,
                     input logic [3:0] t_rank, input logic inc, input int n);
      @(posedge clk);
      th <= t_th;
      trip <= t_trip;
      dimm <= t_dimm;
      tc <= t_tc;
      rc <= t_rc;
      tt <= t_tt;
      rank <= t_rank;
      repeat (n) @(posedge clk);
      th <= 1'b0;
      tc <= 1'b0;
      tt <= 1'b0;
      exp_cnt = exp_cnt + (inc ? 32'(n) : 32'h0000_0000);
      #1 `CHK(event_count, exp_cnt)
   endtask
   task automatic results;
      $display("checks %0d mismatches %0d", n_checks, fail_count);
      if (fail_count == 0 && n_checks > 0) $display("verification passed");
      else $display("verification failed");
      $finish;
   endtask
   always @(posedge clk) begin
      cycles++;
      if (cycles == 5000) begin
         fail_count++;
         results;
      end
   end
   // ------------------------------------------------------------
   // Tests
   // ------------------------------------------------------------
   initial begin
      exp_cnt = 32'h0000_0000;
      repeat (2) @(posedge clk);
      rst <= 1'b0;
      // Reset values, masking, refused address
      for (int i = 0; i < 4; i++) begin
         apb(1'b0, 12'(4 * i), 32'h0000_0000);
         `CHK(rd, 32'h0000_0000)
      end
      apb(1'b1, perf_filter_pkg::EVSEL_OFF, 32'hFFFF_FFFF);
      apb(1'b0, perf_filter_pkg::EVSEL_OFF, 32'h0000_0000);
      `CHK(rd, 32'h0000_00FF)
      apb(1'b1, perf_filter_pkg::THRFLT_OFF, 32'hFFFF_FFFF);
      apb(1'b0, perf_filter_pkg::THRFLT_OFF, 32'h0000_0000);
      `CHK(rd, 32'h0000_07FF)
      apb(1'b1, perf_filter_pkg::PGFLT_OFF, 32'hFFFF_FFFF);
      apb(1'b0, perf_filter_pkg::PGFLT_OFF, 32'h0000_0000);
      `CHK(rd, 32'h0000_03FF)
      apb(1'b1, 12'h010, 32'h0000_0012);
      `CHK(er, 1'b1)
      apb(1'b0, 12'h010, 32'h0000_0000);
      `CHK({er, rd}, {1'b1, 32'h0000_0000})
      ev(1'b1, 2'h3, 3'h7, 1'b1, 1'b1, 1'b1, 4'hF, 1'b0, 2);
      $display("test registers done");
      // Thermal crossings, any DIMM then one DIMM
      apb(1'b1, perf_filter_pkg::EVSEL_OFF, 32'h0000_0004);
      for (int t = 0; t < 4; t++) begin
         apb(1'b1, perf_filter_pkg::THRFLT_OFF, (32'(t) << 9) | 32'h0000_0008);
         ev(1'b1, 2'(t), 3'(t), 1'b0, 1'b0, 1'b0, 4'h0, 1'b1, 1);
         ev(1'b1, 2'(t + 1), 3'h0, 1'b0, 1'b0, 1'b0, 4'h0, 1'b0, 1);
      end
      apb(1'b1, perf_filter_pkg::THRFLT_OFF, 32'h0000_0650);
      ev(1'b1, 2'h3, 3'h5, 1'b0, 1'b0, 1'b0, 4'h0, 1'b1, 3);
      ev(1'b1, 2'h3, 3'h2, 1'b0, 1'b0, 1'b0, 4'h0, 1'b0, 1);
      ev(1'b1, 2'h2, 3'h5, 1'b0, 1'b0, 1'b0, 4'h0, 1'b0, 1);
      ev(1'b0, 2'h3, 3'h5, 1'b1, 1'b1, 1'b1, 4'h0, 1'b0, 1);
      $display("test thermal done");
      // Translated command inserts in all four modes
      apb(1'b1, perf_filter_pkg::EVSEL_OFF, 32'h0000_0012);
      for (int m = 0; m < 4; m++) begin
         apb(1'b1, perf_filter_pkg::PGFLT_OFF, 32'(m) << 8);
         ev(1'b0, 2'h0, 3'h0, 1'b1, 1'b0, 1'b0, 4'h0, !m[0], 2);
         ev(1'b0, 2'h0, 3'h0, 1'b1, 1'b1, 1'b0, 4'h0, m <= 1, 2);
      end
      ev(1'b1, 2'h0, 3'h0, 1'b0, 1'b0, 1'b1, 4'h0, 1'b0, 1);
      $display("test translated done");
      // Throttle conflicts on any rank then one rank
      apb(1'b1, perf_filter_pkg::EVSEL_OFF, 32'h0000_0019);
      apb(1'b1, perf_filter_pkg::PGFLT_OFF, 32'h0000_0000);
      ev(1'b1, 2'h0, 3'h0, 1'b1, 1'b0, 1'b1, 4'h3, 1'b1, 2);
      apb(1'b1, perf_filter_pkg::PGFLT_OFF, 32'h0000_0026);
      ev(1'b0, 2'h0, 3'h0, 1'b0, 1'b0, 1'b1, 4'h9, 1'b1, 1);
      ev(1'b0, 2'h0, 3'h0, 1'b0, 1'b0, 1'b1, 4'h3, 1'b0, 1);
      $display("test throttle done");
      // Counter load and read back
      apb(1'b1, perf_filter_pkg::COUNT_OFF, 32'hFFFF_FFF0);
      exp_cnt = 32'hFFFF_FFF0;
      apb(1'b0, perf_filter_pkg::COUNT_OFF, 32'h0000_0000);
      `CHK(rd, exp_cnt)
      ev(1'b0, 2'h0, 3'h0, 1'b0, 1'b0, 1'b1, 4'h9, 1'b1, 1);
      apb(1'b0, perf_filter_pkg::COUNT_OFF, 32'h0000_0000);
      `CHK(rd, exp_cnt)
      $display("test counter done");
      results;
   end
endmodule
